// ---- sim/cci_cmp_model.sv ----
module cci_cmp_model (
    input wire logic                      clk,
    input wire cci_pkg::cci_analog_ctrl_t analog_ctrl,
    input wire logic                      level,
    output logic                          cmp_raw
);
    timeunit 1ns;
    timeprecision 1ps;
    // a powered-down core gives no comparison, output sits low
    always_ff @(posedge clk)
        cmp_raw <= analog_ctrl.power_off ? 1'b0 : level;
endmodule : cci_cmp_model

// ---- sim/cci_top_monitor.sv ----
module cci_top_monitor (
    input wire logic                      clk,
    input wire logic                      srst,
    input wire logic                      psel,
    input wire logic                      penable,
    input wire logic                      pwrite,
    input wire logic                      pready,
    input wire logic [7:0]                paddr,
    input wire logic [31:0]               pwdata,
    input wire logic                      cmp_raw,
    input wire logic                      global_irq_enable,
    input wire logic                      irq_vector_ack,
    input wire logic                      cmp_irq,
    input wire logic                      capture_trigger,
    input wire cci_pkg::cci_analog_ctrl_t analog_ctrl
);
    logic wr;
    assign wr = psel && penable && pwrite && !pready;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    a_capture_sync: assert property (
        $rose(capture_trigger) |-> $past(cmp_raw, 2) || $past(cmp_raw, 3))
        else $error("capture rose without synced output");
    a_global_gate: assert property (
        !global_irq_enable |=> !cmp_irq)
        else $error("irq raised without global enable");
    a_ack_clears: assert property (
        irq_vector_ack && $stable(cmp_raw) && $past(cmp_raw, 2) == cmp_raw
        && $past(cmp_raw, 3) == cmp_raw && $past(cmp_raw, 4) == cmp_raw
        |=> !cmp_irq)
        else $error("irq survived vector ack");
    a_power_bandgap: assert property (
        wr && paddr == cci_pkg::ADDR_CMP_CS |-> ##2
        analog_ctrl.power_off == $past(pwdata[7], 2)
        && analog_ctrl.pos_bandgap == $past(pwdata[6], 2))
        else $error("power or bandgap control wrong");
    a_conv_blocks_mux: assert property (
        wr && paddr == cci_pkg::ADDR_CONV_EN && pwdata[0] |-> ##2
        !analog_ctrl.neg_from_mux)
        else $error("mux path kept with converter on");
    a_channel_pick: assert property (
        wr && paddr == cci_pkg::ADDR_CONV_MUX |-> ##2
        analog_ctrl.neg_channel == $past(pwdata[2:0], 2))
        else $error("channel select wrong");
    a_capture_off: assert property (
        wr && paddr == cci_pkg::ADDR_CMP_CS && !pwdata[2] |-> ##2
        !capture_trigger)
        else $error("capture routed while link off");
    a_enable_off: assert property (
        wr && paddr == cci_pkg::ADDR_CMP_CS && !pwdata[3] |-> ##2 !cmp_irq)
        else $error("irq raised while disabled");
    c_irq: cover property (cmp_irq);
    c_capture: cover property (capture_trigger);
    c_mux: cover property (analog_ctrl.neg_from_mux);
endmodule : cci_top_monitor

bind cci_top cci_top_monitor u_mon (.*);

// ---- sim/comparator_control_irq_test.sv ----
module comparator_control_irq_test;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] q;
        logic        e;
    } cci_row_t;
    logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, lvl = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, cmp_raw, cmp_irq, capture_trigger, err, ex;
    logic global_irq_enable = 0, irq_vector_ack = 0;
    cci_pkg::cci_analog_ctrl_t analog_ctrl;
    int num_errors = 0, total_checks = 0;
    cci_row_t rows [5] = '{
        '{cci_pkg::ADDR_SFIO, 32'h8, 32'h8, 1'b0},
        '{cci_pkg::ADDR_CONV_MUX, 32'h5, 32'h5, 1'b0},
        '{cci_pkg::ADDR_CONV_EN, 32'h1, 32'h1, 1'b0},
        '{cci_pkg::ADDR_CMP_CS, 32'hc4, 32'hc4, 1'b0},
        '{8'h10, 32'hff, 32'h0, 1'b1}};
    always #2 clk = ~clk;
    cci_top DUT (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .cmp_raw, .global_irq_enable,
        .irq_vector_ack, .cmp_irq, .capture_trigger, .analog_ctrl);
    cci_cmp_model u_cmp (.clk, .analog_ctrl, .level(lvl), .cmp_raw);
    task automatic complete_run();
        if (num_errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    task automatic chk(input string n, input logic [31:0] x,
                       input logic [31:0] g);
        total_checks++;
        if (g !== x)
        begin
            $display("CHECK FAILED %s expected %h seen %h", n, x, g);
            num_errors++;
        end
    endtask : chk
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge clk);
        end
        if (n == 20)
            num_errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    initial
    begin
        repeat (4000) @(posedge clk);
        num_errors++;
        complete_run();
    end
    initial
    begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        apb(cci_pkg::ADDR_CMP_CS, 1'b0, 32'h0);
        chk("cs reset", {24'h0, cci_pkg::CS_RESET}, rd);
        foreach (rows[i])
        begin
            apb(rows[i].a, 1'b1, rows[i].d);
            apb(rows[i].a, 1'b0, 32'h0);
            chk("read", rows[i].q, rd);
            chk("slverr", {31'h0, rows[i].e}, {31'h0, err});
        end
        chk("analog", 32'h35, {26'h0, analog_ctrl});
        apb(cci_pkg::ADDR_CONV_EN, 1'b1, 32'h0);
        chk("analog", 32'h3d, {26'h0, analog_ctrl});
        global_irq_enable <= 1'b1;
        apb(cci_pkg::ADDR_CMP_CS, 1'b1, 32'h4);
        lvl <= 1'b1;
        repeat (6) @(posedge clk);
        chk("capture", 32'h1, {31'h0, capture_trigger});
        apb(cci_pkg::ADDR_CMP_CS, 1'b0, 32'h0);
        chk("status", 32'h34, rd);
        lvl <= 1'b0;
        repeat (6) @(posedge clk);
        chk("capture", 32'h0, {31'h0, capture_trigger});
        for (int m = 0; m < 4; m++)
        begin
            apb(cci_pkg::ADDR_CMP_CS, 1'b1, m);
            apb(cci_pkg::ADDR_CMP_CS, 1'b1, 32'h18 | m);
            lvl <= 1'b1;
            repeat (6) @(posedge clk);
            ex = m == cci_pkg::MODE_TOGGLE || m == cci_pkg::MODE_RISE;
            chk("irq rise", {31'h0, ex}, {31'h0, cmp_irq});
            irq_vector_ack <= 1'b1;
            @(posedge clk);
            irq_vector_ack <= 1'b0;
            repeat (3) @(posedge clk);
            chk("irq ack", 32'h0, {31'h0, cmp_irq});
            lvl <= 1'b0;
            repeat (6) @(posedge clk);
            ex = m == cci_pkg::MODE_TOGGLE || m == cci_pkg::MODE_FALL;
            chk("irq fall", {31'h0, ex}, {31'h0, cmp_irq});
            apb(cci_pkg::ADDR_CMP_CS, 1'b1, 32'h18 | m);
            apb(cci_pkg::ADDR_CMP_CS, 1'b0, 32'h0);
            chk("flag clear", 32'h08 | m, rd);
        end
        complete_run();
    end
endmodule : comparator_control_irq_test

// ---- src/cci_pkg.sv ----
package cci_pkg;

    // register byte addresses on the apb bus
    localparam logic [7:0] ADDR_SFIO     = 8'h00;
    localparam logic [7:0] ADDR_CMP_CS   = 8'h04;
    localparam logic [7:0] ADDR_CONV_MUX = 8'h08;
    localparam logic [7:0] ADDR_CONV_EN  = 8'h0c;

    // special_function_io fields
    localparam int SFIO_MUX_EN_BIT = 3;

    // comparator_control_status fields
    localparam int CS_POWER_OFF_BIT = 7;
    localparam int CS_BANDGAP_BIT   = 6;
    localparam int CS_OUTPUT_BIT    = 5;
    localparam int CS_FLAG_BIT      = 4;
    localparam int CS_IRQ_EN_BIT    = 3;
    localparam int CS_CAPTURE_BIT   = 2;
    localparam int CS_MODE_HI_BIT   = 1;
    localparam int CS_MODE_LO_BIT   = 0;

    // converter_mux_ctrl / converter enable fields
    localparam int MUX_CHAN_LSB   = 0;
    localparam int CONV_EN_BIT    = 0;

    // reset values
    localparam logic [7:0] SFIO_RESET = 8'h00;
    localparam logic [7:0] CS_RESET   = 8'h00;
    localparam logic [2:0] CHAN_RESET = 3'h0;

    // interrupt mode field codes
    localparam logic [1:0] MODE_TOGGLE   = 2'h0;
    localparam logic [1:0] MODE_RESERVED = 2'h1;
    localparam logic [1:0] MODE_FALL     = 2'h2;
    localparam logic [1:0] MODE_RISE     = 2'h3;

    // synchroniser stages for the raw comparator output
    localparam int SYNC_STAGES = 2;

    // analog-facing controls, one bundle toward the comparator core
    typedef struct packed {
        logic       power_off;
        logic       pos_bandgap;
        logic       neg_from_mux;
        logic [2:0] neg_channel;
    } cci_analog_ctrl_t;

endpackage : cci_pkg

// ---- src/cci_sync.sv ----
module cci_sync #(
    parameter int STAGES = 2
) (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic din,
    output logic      dout
);

    logic [STAGES-1:0] stage_r;
    logic [STAGES-1:0] stage_nxt;

    // first stage feeds only the next stage
    always_comb
    begin
        stage_nxt = {stage_r[STAGES-2:0], din};
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            stage_r <= '0;
        else
            stage_r <= stage_nxt;
    end

    assign dout = stage_r[STAGES-1];

endmodule : cci_sync

// ---- src/cci_top.sv ----
// What this block does
// [RULE_01] mux enable set and converter off: negative input from channel mux
// [RULE_02] on mux path the 3-bit channel select picks channel 0 to 7
// [RULE_03] writing one to bit 7 powers comparator off, any time
// [RULE_04] software clears irq enable before changing power-off bit
// [RULE_05] bit 6 set feeds bandgap to positive input, else pin
// [RULE_06] raw output synchronised, readable status bit, one to two cycles
// [RULE_07] flag bit 4 set when output event matches selected mode
// [RULE_08] flag cleared by vector execution or by writing one
// [RULE_09] irq requested only with flag, enable bit 3, global enable
// [RULE_10] capture-link bit 2 routes output to timer capture, else none
// [RULE_11] software sets timer capture irq enable for capture interrupt
// [RULE_12] mode 00 toggle, 10 falling, 11 rising, 01 reserved
// [RULE_13] software clears irq enable before changing mode field
// [RULE_14] edges found by comparing synced output with previous cycle
// [RULE_15] reserved mode 01 never sets the flag
//
// Our own choices: the placing of the registers and the APB interface to the registers.
module cci_top (
    input  wire logic                      clk,
    input  wire logic                      srst,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    output logic                           pready,
    output logic [31:0]                    prdata,
    output logic                           pslverr,
    input  wire logic                      cmp_raw,
    input  wire logic                      global_irq_enable,
    input  wire logic                      irq_vector_ack,
    output logic                           cmp_irq,
    output logic                           capture_trigger,
    output cci_pkg::cci_analog_ctrl_t      analog_ctrl
);

    logic [7:0]  sfio_r;
    logic [7:0]  sfio_nxt;
    logic [7:0]  cs_r;
    logic [7:0]  cs_nxt;
    logic [2:0]  chan_r;
    logic [2:0]  chan_nxt;
    logic        conv_en_r;
    logic        conv_en_nxt;
    logic        out_prev_r;
    logic        out_prev_nxt;
    logic        flag_r;
    logic        flag_nxt;
    logic        irq_r;
    logic        irq_nxt;
    logic        cap_r;
    logic        cap_nxt;
    logic        pready_r;
    logic        pready_nxt;
    logic        pslverr_r;
    logic        pslverr_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    cci_pkg::cci_analog_ctrl_t actl_r;
    cci_pkg::cci_analog_ctrl_t actl_nxt;
    logic        out_sync;
    logic        event_hit;
    logic        wr_strobe;
    logic        rd_strobe;

    cci_sync #(
        .STAGES (cci_pkg::SYNC_STAGES)
    ) u_sync (
        .clk  (clk),
        .srst (srst),
        .din  (cmp_raw),
        .dout (out_sync)
    ); // [RULE_06]

    // only the four register words answer; anything else errors
    function automatic logic addr_known(input logic [7:0] a);
        addr_known = 1'b0;
        unique case (a)
            cci_pkg::ADDR_SFIO:     addr_known = 1'b1;
            cci_pkg::ADDR_CMP_CS:   addr_known = 1'b1;
            cci_pkg::ADDR_CONV_MUX: addr_known = 1'b1;
            cci_pkg::ADDR_CONV_EN:  addr_known = 1'b1;
            default:                addr_known = 1'b0;
        endcase
    endfunction : addr_known

    // mode decode against the previous synced sample
    function automatic logic mode_match(
        input logic [1:0] mode,
        input logic       cur,
        input logic       prev
    );
        mode_match = 1'b0;
        unique case (mode)
            cci_pkg::MODE_TOGGLE:
            begin
                mode_match = cur ^ prev; // [RULE_12]
            end
            // reserved code is inert so a stray write cannot raise the flag
            cci_pkg::MODE_RESERVED:
            begin
                mode_match = 1'b0; // [RULE_15]
            end
            cci_pkg::MODE_FALL:
            begin
                mode_match = prev & ~cur; // [RULE_12]
            end
            cci_pkg::MODE_RISE:
            begin
                mode_match = cur & ~prev; // [RULE_12]
            end
        endcase
    endfunction : mode_match

    // apb access phase takes two cycles, pready registered
    assign wr_strobe = psel && penable && !pready_r && pwrite;
    assign rd_strobe = psel && penable && !pready_r && !pwrite;

    // handshake: one wait state, so pready is a flop like every output
    always_comb
    begin
        pready_nxt  = psel && penable && !pready_r;
        pslverr_nxt = psel && penable && !pready_r && !addr_known(paddr);
    end

    // register writes
    always_comb
    begin
        sfio_nxt    = sfio_r;
        cs_nxt      = cs_r;
        chan_nxt    = chan_r;
        conv_en_nxt = conv_en_r;
        if (wr_strobe)
        begin
            unique case (paddr)
                cci_pkg::ADDR_SFIO:
                    sfio_nxt = pwdata[7:0];
                cci_pkg::ADDR_CMP_CS:
                    // output and flag bits are stored from the bus but replaced by out_sync and flag_r on read
                    cs_nxt = pwdata[7:0]; // [RULE_03]
                cci_pkg::ADDR_CONV_MUX:
                    chan_nxt = pwdata[cci_pkg::MUX_CHAN_LSB +: 3];
                cci_pkg::ADDR_CONV_EN:
                    conv_en_nxt = pwdata[cci_pkg::CONV_EN_BIT];
                default:
                    sfio_nxt = sfio_r;
            endcase
        end
    end

    // read data, held between reads
    always_comb
    begin
        prdata_nxt = prdata_r;
        if (rd_strobe)
        begin
            prdata_nxt = 32'h0000_0000;
            unique case (paddr)
                cci_pkg::ADDR_SFIO:
                    prdata_nxt[7:0] = sfio_r;
                cci_pkg::ADDR_CMP_CS:
                begin
                    prdata_nxt[7:0] = cs_r;
                    prdata_nxt[cci_pkg::CS_OUTPUT_BIT] = out_sync; // [RULE_06]
                    prdata_nxt[cci_pkg::CS_FLAG_BIT]   = flag_r;
                end
                cci_pkg::ADDR_CONV_MUX:
                    prdata_nxt[cci_pkg::MUX_CHAN_LSB +: 3] = chan_r;
                cci_pkg::ADDR_CONV_EN:
                    prdata_nxt[cci_pkg::CONV_EN_BIT] = conv_en_r;
                default:
                    prdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // event detection and interrupt flag
    assign event_hit = mode_match(
        cs_r[cci_pkg::CS_MODE_HI_BIT:cci_pkg::CS_MODE_LO_BIT],
        out_sync, out_prev_r); // [RULE_07] [RULE_14]

    always_comb
    begin
        out_prev_nxt = out_sync; // [RULE_14]
        flag_nxt     = flag_r;
        if (irq_vector_ack)
            flag_nxt = 1'b0; // [RULE_08]
        if (wr_strobe && paddr == cci_pkg::ADDR_CMP_CS &&
            pwdata[cci_pkg::CS_FLAG_BIT])
            flag_nxt = 1'b0; // [RULE_08]
        // a new event beats a clear in the same cycle
        if (event_hit)
            flag_nxt = 1'b1; // [RULE_07]
    end

    // request follows the next flag so it never lags the flag bit
    always_comb
    begin
        irq_nxt = flag_nxt && cs_nxt[cci_pkg::CS_IRQ_EN_BIT] &&
                  global_irq_enable; // [RULE_09]
        cap_nxt = cs_r[cci_pkg::CS_CAPTURE_BIT] & out_sync; // [RULE_10]
    end

    // analog core controls
    always_comb
    begin
        actl_nxt.power_off   = cs_nxt[cci_pkg::CS_POWER_OFF_BIT]; // [RULE_03]
        actl_nxt.pos_bandgap = cs_nxt[cci_pkg::CS_BANDGAP_BIT];   // [RULE_05]
        actl_nxt.neg_from_mux = sfio_nxt[cci_pkg::SFIO_MUX_EN_BIT] &&
                                !conv_en_nxt;                     // [RULE_01]
        actl_nxt.neg_channel = chan_nxt;                          // [RULE_02]
    end

    // software-visible registers
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            sfio_r    <= cci_pkg::SFIO_RESET;
            cs_r      <= cci_pkg::CS_RESET;
            chan_r    <= cci_pkg::CHAN_RESET;
            conv_en_r <= 1'b0;
        end
        else
        begin
            sfio_r    <= sfio_nxt;
            cs_r      <= cs_nxt;
            chan_r    <= chan_nxt;
            conv_en_r <= conv_en_nxt;
        end
    end

    // bus answer
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end
        else
        begin
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r  <= prdata_nxt;
        end
    end

    // event history, flag and requests
    // previous sample resets to the synchroniser's reset level: no false edge
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            out_prev_r <= 1'b0;
            flag_r     <= 1'b0;
            irq_r      <= 1'b0;
            cap_r      <= 1'b0;
        end
        else
        begin
            out_prev_r <= out_prev_nxt;
            flag_r     <= flag_nxt;
            irq_r      <= irq_nxt;
            cap_r      <= cap_nxt;
        end
    end

    // analog core controls
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            actl_r <= '0;
        end
        else
        begin
            actl_r <= actl_nxt;
        end
    end

    assign pready          = pready_r;
    assign pslverr         = pslverr_r;
    assign prdata          = prdata_r;
    assign cmp_irq         = irq_r;
    assign capture_trigger = cap_r;
    assign analog_ctrl     = actl_r;

endmodule : cci_top
